// file: common/modem_cfg_params.svh
`ifndef MODEM_CFG_PARAMS_SVH
`define MODEM_CFG_PARAMS_SVH

`define ADDR_W                6
`define OFS_MODEM_CFG_TWO     6'h12
`define OFS_SPACING_MANT      6'h14
`define OFS_DEVIATION         6'h15

`define RST_SYNC_MODE         3'h2
`define RST_MODULATION_FORMAT        3'h0
`define RST_SPACING_MANT      8'hf8
`define RST_DEV_EXP           3'h4
`define RST_DEV_MANT          3'h7

`define FLD_HI_LSB            4
`define FLD_LO_LSB            0

`define SPACING_IMPLIED_ONE   9'h100
`define DEV_IMPLIED_ONE       4'h8

`define TOL_16_LOOSE          5'h01
`define TOL_16_STRICT         5'h00
`define TOL_32                6'h02
`define BITS_16               6'h10
`define BITS_32               6'h20

`define PREAMBLE_DEFAULT      32

`endif

// file: common/modem_cfg_pkg.sv
package modem_cfg_pkg;

    typedef logic [2:0] sync_mode_t;
    typedef logic [2:0] modulation_format_t;

    typedef enum logic [2:0] {
        FMT_FSK  = 3'h0,
        FMT_GFSK = 3'h1,
        FMT_OOK  = 3'h3,
        FMT_MSK  = 3'h7
    } mod_fmt_code_t;

    typedef enum {
        TX_IDLE,
        TX_PREAMBLE,
        TX_SYNC
    } tx_phase_t;

endpackage

// file: rtl/sync_mismatch_count.sv
`timescale 1ns/1ps
`default_nettype none

module sync_mismatch_count #(
    parameter int WIDTH = 16,
    parameter int CW    = 5
) (
    input  wire logic [WIDTH-1:0] seen_in,
    input  wire logic [WIDTH-1:0] expect_in,
    output logic      [CW-1:0]    errors_out
);

    initial begin
        if (WIDTH < 1 || (1 << CW) <= WIDTH) begin
            $error("sync_mismatch_count: CW too narrow for WIDTH");
        end
    end

    wire [WIDTH-1:0] diff = seen_in ^ expect_in;

    always_comb begin
        errors_out = '0;
        for (int i = 0; i < WIDTH; i++) begin
            errors_out = errors_out + CW'(diff[i]);
        end
    end

endmodule

`default_nettype wire

// file: rtl/modem_sync_spacing_deviation_cfg.sv
`timescale 1ns/1ps
`default_nettype none

`include "modem_cfg_params.svh"

module modem_sync_spacing_deviation_cfg
    import modem_cfg_pkg::*;
#(
    parameter int PREAMBLE_BITS = `PREAMBLE_DEFAULT
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          reset_in,
    input  wire logic [`ADDR_W-1:0]            reg_addr_in,
    input  wire logic                          reg_wr_in,
    input  wire logic [7:0]                    reg_wdata_in,
    output logic      [7:0]                    reg_rdata_out,
    input  wire logic [15:0]                   sync_word_in,
    input  wire logic                          carrier_above_in,
    input  wire logic                          rx_bit_in,
    input  wire logic                          rx_bit_valid_in,
    input  wire logic                          rx_restart_in,
    output logic                               sync_found_out,
    output logic                               rx_qualified_out,
    input  wire logic                          tx_start_in,
    input  wire logic                          tx_bit_strobe_in,
    output logic                               tx_bit_out,
    output logic                               tx_bit_active_out,
    output logic                               tx_done_out,
    output modem_cfg_pkg::sync_mode_t          sync_mode_out,
    output modem_cfg_pkg::modulation_format_t  modulation_format_out,
    output logic      [7:0]                    spacing_mantissa_out,
    output logic      [8:0]                    spacing_multiplier_out,
    output logic      [10:0]                   deviation_multiplier_out,
    output logic      [2:0]                    msk_phase_fraction_out,
    output logic                               msk_selected_out
);

    import modem_cfg_pkg::*;

    // Six-bit counter bounds the preamble length
    initial begin
        if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 63) begin
            $error("PREAMBLE_BITS must be 1..63");
        end
    end

    // Configuration registers
    sync_mode_t         sync_mode_q;
    modulation_format_t modulation_format_q;
    logic [7:0]         spacing_m_q;
    logic [2:0]         dev_e_q;
    logic [2:0]         dev_m_q;

    wire at_cfg_two = (reg_addr_in == `OFS_MODEM_CFG_TWO);
    wire at_spacing = (reg_addr_in == `OFS_SPACING_MANT);
    wire at_dev     = (reg_addr_in == `OFS_DEVIATION);

    wire wr_cfg_two = reg_wr_in && at_cfg_two;
    wire wr_spacing = reg_wr_in && at_spacing;
    wire wr_dev     = reg_wr_in && at_dev;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sync_mode_q  <= `RST_SYNC_MODE;
            modulation_format_q <= `RST_MODULATION_FORMAT;
        end else if (wr_cfg_two) begin
            sync_mode_q  <= reg_wdata_in[`FLD_LO_LSB +: 3];
            modulation_format_q <= reg_wdata_in[`FLD_HI_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            spacing_m_q <= `RST_SPACING_MANT;
        end else if (wr_spacing) begin
            spacing_m_q <= reg_wdata_in;
        end
    end

    // Bits 7 and 3 are not stored, so writes to them are lost
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            dev_e_q <= `RST_DEV_EXP;
            dev_m_q <= `RST_DEV_MANT;
        end else if (wr_dev) begin
            dev_e_q <= reg_wdata_in[`FLD_HI_LSB +: 3];
            dev_m_q <= reg_wdata_in[`FLD_LO_LSB +: 3];
        end
    end

    // Readback, unmapped and reserved bits read zero
    wire [7:0] rd_cfg_two = {1'b0, modulation_format_q, 1'b0, sync_mode_q};
    wire [7:0] rd_dev     = {1'b0, dev_e_q, 1'b0, dev_m_q};
    wire [7:0] rd_mux     = at_cfg_two ? rd_cfg_two :
                            at_spacing ? spacing_m_q :
                            at_dev     ? rd_dev : 8'h00;

    // Derived frequency factors
    wire       is_msk    = (modulation_format_q == FMT_MSK);
    wire       is_fsk    = (modulation_format_q == FMT_FSK) || (modulation_format_q == FMT_GFSK);
    // Implied leading one gives a multiplier of 256 to 511
    wire [8:0] spc_mult  = `SPACING_IMPLIED_ONE + 9'(spacing_m_q);
    wire [3:0] dev_mant4 = `DEV_IMPLIED_ONE + 4'(dev_m_q);
    // OOK and MSK carry no frequency deviation
    wire [10:0] dev_mult = is_fsk ? (11'(dev_mant4) << dev_e_q) : 11'h000;
    wire [2:0] msk_frac  = is_msk ? dev_m_q : 3'h0;

    // Field mirrors, one cycle behind the registers
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            reg_rdata_out         <= 8'h00;
            sync_mode_out         <= `RST_SYNC_MODE;
            modulation_format_out <= `RST_MODULATION_FORMAT;
            spacing_mantissa_out  <= `RST_SPACING_MANT;
        end else begin
            reg_rdata_out         <= rd_mux;
            sync_mode_out         <= sync_mode_q;
            modulation_format_out <= modulation_format_q;
            spacing_mantissa_out  <= spacing_m_q;
        end
    end

    // Factors stay zero until the first edge out of reset
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            spacing_multiplier_out   <= 9'h000;
            deviation_multiplier_out <= 11'h000;
            msk_phase_fraction_out   <= 3'h0;
            msk_selected_out         <= 1'b0;
        end else begin
            spacing_multiplier_out   <= spc_mult;
            deviation_multiplier_out <= dev_mult;
            msk_phase_fraction_out   <= msk_frac;
            msk_selected_out         <= is_msk;
        end
    end

    // Mode decode, bit 2 adds carrier gating, bits 1:0 pick the sync length
    wire sync_used  = (sync_mode_q[1:0] != 2'b00);
    wire sync_32    = (sync_mode_q[1:0] == 2'b11);
    wire need_cs    = sync_mode_q[2];
    wire carrier_ok = !need_cs || carrier_above_in;
    // Mode x01 forgives one wrong bit, x10 none
    wire [4:0] tol16 = (sync_mode_q[1:0] == 2'b01) ? `TOL_16_LOOSE : `TOL_16_STRICT;

    // Receive search, newest bit at the LSB
    logic [31:0] rx_shift_q;
    logic [5:0]  bits_seen_q;
    logic        bit_taken_q;
    logic        found_q;
    logic [4:0]  err16;
    logic [5:0]  err32;

    sync_mismatch_count #(.WIDTH(16), .CW(5)) u_cmp16 (
        .seen_in    (rx_shift_q[15:0]),
        .expect_in  (sync_word_in),
        .errors_out (err16)
    );

    sync_mismatch_count #(.WIDTH(32), .CW(6)) u_cmp32 (
        .seen_in    (rx_shift_q),
        .expect_in  ({sync_word_in, sync_word_in}),
        .errors_out (err32)
    );

    wire enough16 = (bits_seen_q >= `BITS_16);
    wire enough32 = (bits_seen_q >= `BITS_32);
    wire match16  = enough16 && (err16 <= tol16);
    wire match32  = enough32 && (err32 <= `TOL_32);
    wire search_on = bit_taken_q && sync_used && !found_q;
    wire sel_match = sync_32 ? match32 : match16;
    wire hit       = search_on && carrier_ok && sel_match;
    // Without a search, qualification rests on the bit 2 carrier gate alone
    wire qualify   = sync_used ? (found_q || hit) : carrier_ok;

    // Shift and count
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || rx_restart_in) begin
            rx_shift_q  <= 32'h0000_0000;
            bits_seen_q <= 6'h00;
            bit_taken_q <= 1'b0;
        end else begin
            bit_taken_q <= rx_bit_valid_in;
            if (rx_bit_valid_in) begin
                rx_shift_q <= {rx_shift_q[30:0], rx_bit_in};
            end
            // Saturate so a long preamble never wraps the count
            if (rx_bit_valid_in && (bits_seen_q != `BITS_32)) begin
                bits_seen_q <= bits_seen_q + 6'h01;
            end
        end
    end

    // Restart outranks a hit in the same cycle, like a local reset
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || rx_restart_in) begin
            found_q          <= 1'b0;
            sync_found_out   <= 1'b0;
            rx_qualified_out <= 1'b0;
        end else begin
            if (hit) begin
                found_q <= 1'b1;
            end
            sync_found_out   <= hit;
            rx_qualified_out <= qualify;
        end
    end

    // Transmit preamble and sync
    tx_phase_t  tx_phase_q;
    logic [5:0] tx_cnt_q;
    logic       tx_second_q;

    localparam logic [5:0] PRE_LAST = 6'(PREAMBLE_BITS - 1);

    // Preamble alternates starting with a one, sync goes out MSB first
    wire [3:0] sync_idx  = 4'(~tx_cnt_q[3:0]);
    wire       pre_bit   = ~tx_cnt_q[0];
    wire       pre_end   = (tx_cnt_q == PRE_LAST);
    wire       sync_bit  = sync_word_in[sync_idx];
    wire       sync_next = sync_word_in[4'(sync_idx - 4'h1)];
    wire       sync_wrap = (tx_cnt_q[3:0] == 4'hf);
    wire       sync_last = sync_wrap && (!sync_32 || tx_second_q);

    // One bit per strobe, held between strobes
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_phase_q        <= TX_IDLE;
            tx_cnt_q          <= 6'h00;
            tx_second_q       <= 1'b0;
            tx_bit_out        <= 1'b0;
            tx_bit_active_out <= 1'b0;
            tx_done_out       <= 1'b0;
        end else begin
            tx_done_out <= 1'b0;
            // A start outside idle is ignored
            case (tx_phase_q)
                TX_IDLE: begin
                    if (tx_start_in) begin
                        tx_cnt_q    <= 6'h00;
                        tx_second_q <= 1'b0;
                        if (sync_used) begin
                            tx_phase_q        <= TX_PREAMBLE;
                            tx_bit_active_out <= 1'b1;
                            tx_bit_out        <= 1'b1;
                        end else begin
                            tx_done_out <= 1'b1;
                        end
                    end
                end
                TX_PREAMBLE: begin
                    tx_bit_out <= pre_bit;
                    if (tx_bit_strobe_in) begin
                        if (pre_end) begin
                            tx_phase_q <= TX_SYNC;
                            tx_cnt_q   <= 6'h00;
                            tx_bit_out <= sync_word_in[15];
                        end else begin
                            tx_cnt_q   <= tx_cnt_q + 6'h01;
                            tx_bit_out <= ~pre_bit;
                        end
                    end
                end
                TX_SYNC: begin
                    tx_bit_out <= sync_bit;
                    if (tx_bit_strobe_in) begin
                        if (sync_last) begin
                            tx_phase_q        <= TX_IDLE;
                            tx_bit_active_out <= 1'b0;
                            tx_bit_out        <= 1'b0;
                            tx_done_out       <= 1'b1;
                        end else begin
                            if (sync_wrap) begin
                                tx_second_q <= 1'b1;
                            end
                            tx_cnt_q   <= {2'b00, tx_cnt_q[3:0] + 4'h1};
                            tx_bit_out <= sync_next;
                        end
                    end
                end
                default: begin
                    tx_phase_q        <= TX_IDLE;
                    tx_bit_active_out <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "modem_cfg_params.svh"
module host_model (
    input  wire logic              clk_in,
    output logic [`ADDR_W-1:0]     addr_out,
    output logic                   wr_out,
    output logic [7:0]             wdata_out,
    input  wire logic [7:0]        rdata_in
);
    initial begin
        addr_out  = 6'h3f;
        wr_out    = 1'b0;
        wdata_out = 8'h00;
    end
    // Called only while no frame is in flight
    task automatic wr_reg(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(negedge clk_in);
        wr_out    = 1'b0;
        wdata_out = ~d;
    endtask
    task automatic rd_reg(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        repeat (2) @(negedge clk_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// file: sim/modem_cfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module modem_cfg_asserts
    import modem_cfg_pkg::*;
#(
    parameter int PREAMBLE_BITS = 32
) (
    input wire logic                               sys_clk_in,
    input wire logic                               reset_in,
    input wire logic                               tx_start_in,
    input wire logic                               tx_bit_strobe_in,
    input wire logic                               sync_found_out,
    input wire logic                               tx_bit_out,
    input wire logic                               tx_bit_active_out,
    input wire logic                               tx_done_out,
    input wire modem_cfg_pkg::sync_mode_t          sync_mode_out,
    input wire modem_cfg_pkg::modulation_format_t  modulation_format_out,
    input wire logic [7:0]                         spacing_mantissa_out,
    input wire logic [8:0]                         spacing_multiplier_out,
    input wire logic [2:0]                         msk_phase_fraction_out,
    input wire logic                               msk_selected_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_mode_held;
        $stable(sync_mode_out)[*3];
    endsequence
    sequence s_launch;
        tx_start_in && !tx_bit_active_out;
    endsequence
    property p_spc_mult;
        $stable(spacing_mantissa_out)[*3] |-> spacing_multiplier_out == 9'h100 + spacing_mantissa_out;
    endproperty
    a_spc_mult: assert property (p_spc_mult) else $error("spacing multiplier wrong");
    property p_msk_sel;
        $stable(modulation_format_out)[*2] |-> msk_selected_out == (modulation_format_out == 3'h7);
    endproperty
    a_msk_sel: assert property (p_msk_sel) else $error("msk select wrong");
    property p_msk_frac;
        $stable(modulation_format_out)[*2] ##0 !msk_selected_out |-> msk_phase_fraction_out == 3'h0;
    endproperty
    a_msk_frac: assert property (p_msk_frac) else $error("phase fraction outside msk");
    property p_found_once;
        sync_found_out |=> !sync_found_out[*8];
    endproperty
    a_found_once: assert property (p_found_once) else $error("sync hit repeated");
    property p_no_sync;
        s_mode_held ##0 (sync_mode_out[1:0] == 2'h0) |-> !sync_found_out;
    endproperty
    a_no_sync: assert property (p_no_sync) else $error("sync hit while search off");
    property p_tx_off;
        s_launch ##1 (sync_mode_out[1:0] == 2'h0) |-> tx_done_out && !tx_bit_active_out;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("send without sync mode");
    property p_tx_on;
        s_launch ##1 (sync_mode_out[1:0] != 2'h0) |-> tx_bit_active_out && tx_bit_out;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("send did not start");
    property p_tx_hold;
        tx_bit_active_out && !tx_bit_strobe_in |=> tx_bit_active_out && $stable(tx_bit_out);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx bit moved without strobe");
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "modem_cfg_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t mismatch %h vs %h", $time, g, e); end end
module tb_top;
    import modem_cfg_pkg::*;
    localparam int      PRE = 4;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [15:0]        sw = 16'hb34d;
    logic               car = 1'b0;
    logic               rx_bit = 1'b0;
    logic               rx_v = 1'b0;
    logic               rx_rs = 1'b0;
    logic               tx_st = 1'b0;
    logic               tx_sb = 1'b0;
    logic [5:0]         addr;
    logic               wr;
    logic [7:0]         wdata;
    logic [7:0]         rdata;
    logic               found;
    logic               tx_bit;
    logic               tx_act;
    logic               tx_done;
    logic               qual;
    logic               msk_sel;
    sync_mode_t         mode;
    modulation_format_t fmt;
    logic [7:0]         sp_mant;
    logic [8:0]         sp_mult;
    logic [10:0]        dev_mult;
    logic [2:0]         msk_frac;
    int                 n_errors = 0;
    int                 compares = 0;
    always #20 clk = ~clk;
    host_model u_host_model (.clk_in(clk), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
        .rdata_in(rdata));
    modem_sync_spacing_deviation_cfg #(.PREAMBLE_BITS(PRE)) u_modem_sync_spacing_deviation_cfg (
        .sys_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .sync_word_in(sw),
        .carrier_above_in(car), .rx_bit_in(rx_bit), .rx_bit_valid_in(rx_v),
        .rx_restart_in(rx_rs), .sync_found_out(found), .rx_qualified_out(qual),
        .tx_start_in(tx_st), .tx_bit_strobe_in(tx_sb), .tx_bit_out(tx_bit),
        .tx_bit_active_out(tx_act), .tx_done_out(tx_done), .sync_mode_out(mode),
        .modulation_format_out(fmt), .spacing_mantissa_out(sp_mant),
        .spacing_multiplier_out(sp_mult), .deviation_multiplier_out(dev_mult),
        .msk_phase_fraction_out(msk_frac), .msk_selected_out(msk_sel));
    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host_model.rd_reg(a, d);
        `CHK(d, e)
    endtask
    task automatic t_reset;
        rd_chk(`OFS_MODEM_CFG_TWO, 8'h02);
        rd_chk(`OFS_SPACING_MANT, 8'hf8);
        rd_chk(`OFS_DEVIATION, 8'h47);
        `CHK({sp_mult, dev_mult}, {9'h1f8, 11'h0f0})
        `CHK({mode, fmt, sp_mant}, {3'h2, 3'h0, 8'hf8})
    endtask
    task automatic t_regs;
        u_host_model.wr_reg(`OFS_DEVIATION, 8'hff);
        u_host_model.wr_reg(`OFS_SPACING_MANT, 8'h00);
        u_host_model.wr_reg(6'h20, 8'h5a);
        rd_chk(`OFS_DEVIATION, 8'h77);
        rd_chk(6'h20, 8'h00);
        `CHK({sp_mult, dev_mult}, {9'h100, 11'h780})
        `CHK(sp_mant, 8'h00)
    endtask
    task automatic t_fmt;
        mod_fmt_code_t f;
        f = FMT_FSK;
        repeat (4) begin
            u_host_model.wr_reg(`OFS_MODEM_CFG_TWO, {1'b0, f, 4'h2});
            u_host_model.wr_reg(`OFS_DEVIATION, 8'h35);
            repeat (3) @(negedge clk);
            `CHK({fmt, msk_sel}, {f, f == FMT_MSK})
            `CHK(msk_frac, (f == FMT_MSK) ? 3'h5 : 3'h0)
            `CHK(dev_mult, (f inside {FMT_FSK, FMT_GFSK}) ? 11'h068 : 11'h000)
            f = f.next();
        end
    endtask
    task automatic rx_try(input logic [2:0] m, input logic [31:0] p, input int n,
                          input logic c, input logic e);
        logic hit;
        hit = 1'b0;
        u_host_model.wr_reg(`OFS_MODEM_CFG_TWO, {5'h0, m});
        car = c;
        rx_rs = 1'b1;
        @(negedge clk);
        rx_rs = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            rx_bit = p[i];
            rx_v = 1'b1;
            @(negedge clk);
            hit |= found;
        end
        rx_v = 1'b0;
        repeat (3) begin
            @(negedge clk);
            hit |= found;
        end
        `CHK(hit, e)
        `CHK(qual, (m[1:0] != 2'h0) ? e : (!m[2] || c))
        `CHK(mode, m)
    endtask
    task automatic t_rx;
        rx_try(3'h1, {16'h0, sw ^ 16'h0100}, 16, 1'b0, 1'b1);
        rx_try(3'h5, {16'h0, sw ^ 16'h0101}, 16, 1'b1, 1'b0);
        rx_try(3'h2, {16'h0, sw ^ 16'h8000}, 16, 1'b0, 1'b0);
        rx_try(3'h2, {16'h0, sw}, 16, 1'b0, 1'b1);
        rx_try(3'h3, {sw, sw} ^ 32'h8000_0001, 32, 1'b0, 1'b1);
        rx_try(3'h3, {sw, sw} ^ 32'h8001_0001, 32, 1'b0, 1'b0);
        rx_try(3'h7, {sw, sw}, 32, 1'b0, 1'b0);
        rx_try(3'h6, {16'h0, sw}, 16, 1'b1, 1'b1);
        rx_try(3'h0, {16'h0, sw}, 16, 1'b0, 1'b0);
        rx_try(3'h4, {16'h0, sw}, 16, 1'b0, 1'b0);
    endtask
    task automatic tx_try(input logic [2:0] m, input int n);
        logic b;
        u_host_model.wr_reg(`OFS_MODEM_CFG_TWO, {5'h0, m});
        tx_st = 1'b1;
        @(negedge clk);
        tx_st = 1'b0;
        for (int i = 0; i < n; i++) begin
            b = (i < PRE) ? ~i[0] : sw[15 - (i - PRE) % 16];
            `CHK({tx_act, tx_bit}, {1'b1, b})
            tx_sb = 1'b1;
            @(negedge clk);
        end
        tx_sb = 1'b0;
        `CHK({tx_act, tx_done}, 2'b01)
    endtask
    task automatic t_tx;
        tx_try(3'h0, 0);
        tx_try(3'h4, 0);
        tx_try(3'h2, PRE + 16);
        tx_try(3'h7, PRE + 32);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_fmt();
        t_rx();
        t_tx();
        close_out();
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule
bind modem_sync_spacing_deviation_cfg modem_cfg_asserts #(.PREAMBLE_BITS(PREAMBLE_BITS))
    u_modem_cfg_asserts (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .tx_start_in(tx_start_in), .tx_bit_strobe_in(tx_bit_strobe_in),
    .sync_found_out(sync_found_out), .tx_bit_out(tx_bit_out),
    .tx_bit_active_out(tx_bit_active_out), .tx_done_out(tx_done_out),
    .sync_mode_out(sync_mode_out), .modulation_format_out(modulation_format_out),
    .spacing_mantissa_out(spacing_mantissa_out), .spacing_multiplier_out(spacing_multiplier_out),
    .msk_phase_fraction_out(msk_phase_fraction_out), .msk_selected_out(msk_selected_out));
`default_nettype wire
